// ===== src/bmx_pkg.sv
// Shared types and constants for the byte move execution block
package bmx_pkg;

    localparam int NUM_REGS   = 8;
    localparam int REG_WIDTH  = 32;
    localparam int ADDR_WIDTH = 32;

    // Condition code bit positions
    localparam int CC_I  = 7;
    localparam int CC_UI = 6;
    localparam int CC_N  = 3;
    localparam int CC_Z  = 2;
    localparam int CC_V  = 1;
    localparam int CC_C  = 0;
    localparam logic [7:0] CCR_RESET = 8'h80;

    // Half and byte views of a general register
    typedef enum logic [1:0] {
        VIEW_LOW_WORD  = 2'h0,
        VIEW_UPPER_EXT = 2'h1,
        VIEW_HIGH_BYTE = 2'h2,
        VIEW_LOW_BYTE  = 2'h3
    } bmx_view_e;

    typedef enum logic [3:0] {
        MV_IMM      = 4'h0,
        MV_REG      = 4'h1,
        LD_IND      = 4'h2,
        LD_D16      = 4'h3,
        LD_D24      = 4'h4,
        LD_POSTINC  = 4'h5,
        LD_ABS8     = 4'h6,
        LD_ABS16    = 4'h7,
        LD_ABS24    = 4'h8,
        ST_IND      = 4'h9,
        ST_D16      = 4'hA,
        ST_D24      = 4'hB,
        ST_PREDEC   = 4'hC,
        ST_ABS8     = 4'hD,
        ST_ABS16    = 4'hE,
        ST_ABS24    = 4'hF
    } bmx_mode_e;

    // Byte register select: bit 3 high selects the low byte
    typedef struct packed {
        bmx_mode_e   mode;
        logic [3:0]  dstByte;
        logic [3:0]  srcByte;
        logic [2:0]  addrReg;
        logic [23:0] operand;
    } bmx_op_s;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_RUN    = 2'b01,
        ST_ACCESS = 2'b11,
        ST_FINISH = 2'b10
    } bmx_state_e;

    localparam logic [3:0] STATES_2  = 4'h2;
    localparam logic [3:0] STATES_4  = 4'h4;
    localparam logic [3:0] STATES_6  = 4'h6;
    localparam logic [3:0] STATES_8  = 4'h8;
    localparam logic [3:0] STATES_10 = 4'hA;
    localparam logic [3:0] LEN_2     = 4'h2;
    localparam logic [3:0] LEN_4     = 4'h4;
    localparam logic [3:0] LEN_6     = 4'h6;
    localparam logic [3:0] LEN_8     = 4'h8;
    localparam logic [3:0] ACCESS_CNT = 4'h2;
    localparam logic [3:0] FINISH_CNT = 4'h1;
    localparam logic [23:0] ABS8_PAGE = 24'hFFFFFF;

endpackage

// ===== src/bmx_reg_file.sv
// General register file with word, extension and byte views
`timescale 1ns/1ps
module bmx_reg_file #(
    parameter int NREGS = 8
) (
    input  wire logic                   clock,
    input  wire logic                   rst,
    input  wire logic [3:0]             byteRdSel,
    output logic [7:0]                  byteRdData,
    input  wire logic [2:0]             addrRdSel,
    output logic [31:0]                 addrRdData,
    input  wire logic                   byteWrEn,
    input  wire logic [3:0]             byteWrSel,
    input  wire logic [7:0]             byteWrData,
    input  wire logic                   longWrEn,
    input  wire logic [2:0]             longWrSel,
    input  wire logic [31:0]            longWrData,
    input  wire logic [2:0]             viewSel,
    input  wire bmx_pkg::bmx_view_e     viewKind,
    output logic [15:0]                 viewData
);

    // Select fields are three bits wide, so only eight registers can be reached
    if (NREGS != 8) begin : g_nregs_check
        $error("bmx_reg_file supports exactly eight registers");
    end

    logic [31:0] regs_reg  [NREGS];
    logic [31:0] regs_next [NREGS];

    function automatic logic [7:0] pick_byte(input logic [31:0] r, input logic low);
        pick_byte = low ? r[7:0] : r[15:8];
    endfunction

    // Eight 32-bit registers, halves and bytes
    always_comb begin
        for (int i = 0; i < NREGS; i++) begin
            regs_next[i] = regs_reg[i];
        end
        if (longWrEn) begin
            regs_next[longWrSel] = longWrData;
        end
        if (byteWrEn) begin
            if (byteWrSel[3]) begin
                regs_next[byteWrSel[2:0]][7:0] = byteWrData;
            end else begin
                regs_next[byteWrSel[2:0]][15:8] = byteWrData;
            end
        end
        byteRdData = pick_byte(regs_reg[byteRdSel[2:0]], byteRdSel[3]);
        addrRdData = regs_reg[addrRdSel];
        case (viewKind)
            bmx_pkg::VIEW_LOW_WORD:  viewData = regs_reg[viewSel][15:0];
            bmx_pkg::VIEW_UPPER_EXT: viewData = regs_reg[viewSel][31:16];
            bmx_pkg::VIEW_HIGH_BYTE: viewData = {8'h00, pick_byte(regs_reg[viewSel], 1'b0)};
            default:                 viewData = {8'h00, pick_byte(regs_reg[viewSel], 1'b1)};
        endcase
    end

    always_ff @(posedge clock) begin
        for (int i = 0; i < NREGS; i++) begin
            regs_reg[i] <= rst ? 32'h0000_0000 : regs_next[i];
        end
    end

endmodule

// ===== src/bmx_byte_move.sv
// Byte move decode and execute sequencer with flag update
`timescale 1ns/1ps
module bmx_byte_move (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic                opValid,
    input  wire bmx_pkg::bmx_op_s    opIn,
    output logic                     issueReady,
    output logic                     memReq,
    output logic                     memWrite,
    output logic [31:0]              memAddr,
    output logic [7:0]               memWdata,
    input  wire logic                memAck,
    input  wire logic [7:0]          memRdata,
    output logic [7:0]               condition_code_reg,
    output logic                     done,
    output logic [3:0]               instLen,
    input  wire logic [2:0]          viewSel,
    input  wire bmx_pkg::bmx_view_e  viewKind,
    output logic [15:0]              viewData
);

    function automatic logic [3:0] state_count(input bmx_pkg::bmx_mode_e m);
        case (m)
            bmx_pkg::MV_IMM, bmx_pkg::MV_REG:                  state_count = bmx_pkg::STATES_2;
            bmx_pkg::LD_IND, bmx_pkg::ST_IND, bmx_pkg::LD_ABS8,
            bmx_pkg::ST_ABS8:                                  state_count = bmx_pkg::STATES_4;
            bmx_pkg::LD_D24, bmx_pkg::ST_D24:                  state_count = bmx_pkg::STATES_10;
            bmx_pkg::LD_ABS24, bmx_pkg::ST_ABS24:              state_count = bmx_pkg::STATES_8;
            default:                                           state_count = bmx_pkg::STATES_6;
        endcase
    endfunction

    function automatic logic [3:0] inst_length(input bmx_pkg::bmx_mode_e m);
        case (m)
            bmx_pkg::LD_D16, bmx_pkg::ST_D16, bmx_pkg::LD_ABS16,
            bmx_pkg::ST_ABS16:                                 inst_length = bmx_pkg::LEN_4;
            bmx_pkg::LD_D24, bmx_pkg::ST_D24:                  inst_length = bmx_pkg::LEN_8;
            bmx_pkg::LD_ABS24, bmx_pkg::ST_ABS24:              inst_length = bmx_pkg::LEN_6;
            default:                                           inst_length = bmx_pkg::LEN_2;
        endcase
    endfunction

    function automatic logic is_store(input bmx_pkg::bmx_mode_e m);
        is_store = (m >= bmx_pkg::ST_IND);
    endfunction

    function automatic logic uses_mem(input bmx_pkg::bmx_mode_e m);
        uses_mem = (m != bmx_pkg::MV_IMM) && (m != bmx_pkg::MV_REG);
    endfunction

    bmx_pkg::bmx_state_e state_reg, state_next;
    bmx_pkg::bmx_op_s    op_reg, op_next;
    logic [3:0]          cnt_reg, cnt_next;
    logic [31:0]         ea_reg, ea_next;
    logic [7:0]          data_reg, data_next;
    logic [7:0]          ccr_reg, ccr_next;
    logic                memReq_reg, memReq_next;
    logic                memWrite_reg, memWrite_next;
    logic                done_reg, done_next;
    logic                ready_reg, ready_next;
    logic [3:0]          len_reg, len_next;
    logic [15:0]         view_reg;

    logic [7:0]          srcByte;
    logic [31:0]         baseAddr;
    logic                byteWrEn;
    logic                longWrEn;
    logic [31:0]         longWrData;
    logic [15:0]         viewComb;
    logic                accepted;

    assign accepted = opValid && ready_reg;

    // Source byte and address register are read straight from the issued op
    bmx_reg_file #(
        .NREGS (bmx_pkg::NUM_REGS)
    ) u_regs (
        .clock      (clock),
        .rst        (rst),
        .byteRdSel  (opIn.srcByte),
        .byteRdData (srcByte),
        .addrRdSel  (opIn.addrReg),
        .addrRdData (baseAddr),
        .byteWrEn   (byteWrEn),
        .byteWrSel  (op_reg.dstByte),
        .byteWrData (data_reg),
        .longWrEn   (longWrEn),
        .longWrSel  (op_reg.addrReg),
        .longWrData (longWrData),
        .viewSel    (viewSel),
        .viewKind   (viewKind),
        .viewData   (viewComb)
    );

    // Effective address and operand capture at issue
    always_comb begin
        case (opIn.mode)
            bmx_pkg::LD_D16, bmx_pkg::ST_D16:
                ea_next = baseAddr + {{16{opIn.operand[15]}}, opIn.operand[15:0]};
            bmx_pkg::LD_D24, bmx_pkg::ST_D24:
                ea_next = baseAddr + {{8{opIn.operand[23]}}, opIn.operand};
            bmx_pkg::ST_PREDEC:
                ea_next = baseAddr - 32'h0000_0001;
            bmx_pkg::LD_ABS8, bmx_pkg::ST_ABS8:
                ea_next = {bmx_pkg::ABS8_PAGE, opIn.operand[7:0]};
            bmx_pkg::LD_ABS16, bmx_pkg::ST_ABS16:
                ea_next = {{16{opIn.operand[15]}}, opIn.operand[15:0]};
            bmx_pkg::LD_ABS24, bmx_pkg::ST_ABS24:
                ea_next = {8'h00, opIn.operand};
            default:
                ea_next = baseAddr;
        endcase
        if (!accepted) begin
            ea_next = ea_reg;
        end
    end

    // Sequencer: counts states, holds in the access state while memory waits
    always_comb begin
        state_next    = state_reg;
        op_next       = op_reg;
        cnt_next      = cnt_reg;
        data_next     = data_reg;
        ccr_next      = ccr_reg;
        done_next     = 1'b0;
        len_next      = len_reg;
        byteWrEn      = 1'b0;
        longWrEn      = 1'b0;
        longWrData    = ea_reg;
        case (state_reg)
            bmx_pkg::ST_IDLE: begin
                if (accepted) begin
                    op_next   = opIn;
                    cnt_next  = state_count(opIn.mode) - 4'h1;
                    data_next = (opIn.mode == bmx_pkg::MV_IMM) ? opIn.operand[7:0] : srcByte;
                    if (!uses_mem(opIn.mode) && cnt_next == bmx_pkg::FINISH_CNT) begin
                        state_next = bmx_pkg::ST_FINISH;
                    end else begin
                        state_next = bmx_pkg::ST_RUN;
                    end
                end
            end
            bmx_pkg::ST_RUN: begin
                cnt_next = cnt_reg - 4'h1;
                if (cnt_next == bmx_pkg::ACCESS_CNT && uses_mem(op_reg.mode)) begin
                    state_next = bmx_pkg::ST_ACCESS;
                end else if (cnt_next == bmx_pkg::FINISH_CNT) begin
                    state_next = bmx_pkg::ST_FINISH;
                end
            end
            bmx_pkg::ST_ACCESS: begin
                if (memAck) begin
                    cnt_next   = bmx_pkg::FINISH_CNT;
                    state_next = bmx_pkg::ST_FINISH;
                    if (!is_store(op_reg.mode)) begin
                        data_next = memRdata;
                    end
                    if (op_reg.mode == bmx_pkg::LD_POSTINC) begin
                        longWrEn   = 1'b1;
                        longWrData = ea_reg + 32'h0000_0001;
                    end
                    if (op_reg.mode == bmx_pkg::ST_PREDEC) begin
                        longWrEn = 1'b1;
                    end
                end
            end
            default: begin
                byteWrEn          = !is_store(op_reg.mode);
                ccr_next[bmx_pkg::CC_N] = data_reg[7];
                ccr_next[bmx_pkg::CC_Z] = (data_reg == 8'h00);
                ccr_next[bmx_pkg::CC_V] = 1'b0;
                done_next         = 1'b1;
                len_next          = inst_length(op_reg.mode);
                cnt_next          = 4'h0;
                state_next        = bmx_pkg::ST_IDLE;
            end
        endcase
        // Carry and mask bits are never written above
        ready_next    = (state_next == bmx_pkg::ST_IDLE);
        memReq_next   = (state_next == bmx_pkg::ST_ACCESS);
        memWrite_next = memReq_next && is_store(op_next.mode);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg    <= bmx_pkg::ST_IDLE;
            op_reg       <= '0;
            cnt_reg      <= 4'h0;
            ea_reg       <= 32'h0000_0000;
            data_reg     <= 8'h00;
            ccr_reg      <= bmx_pkg::CCR_RESET;
            memReq_reg   <= 1'b0;
            memWrite_reg <= 1'b0;
            done_reg     <= 1'b0;
            ready_reg    <= 1'b0;
            len_reg      <= 4'h0;
            view_reg     <= 16'h0000;
        end else begin
            state_reg    <= state_next;
            op_reg       <= op_next;
            cnt_reg      <= cnt_next;
            ea_reg       <= ea_next;
            data_reg     <= data_next;
            ccr_reg      <= ccr_next;
            memReq_reg   <= memReq_next;
            memWrite_reg <= memWrite_next;
            done_reg     <= done_next;
            ready_reg    <= ready_next;
            len_reg      <= len_next;
            view_reg     <= viewComb;
        end
    end

    assign issueReady = ready_reg;
    assign memReq     = memReq_reg;
    assign memWrite   = memWrite_reg;
    assign memAddr    = ea_reg;
    // Store data stays stable through any wait states
    assign memWdata   = data_reg;
    assign condition_code_reg        = ccr_reg;
    assign done       = done_reg;
    assign instLen    = len_reg;
    assign viewData   = view_reg;

endmodule

// ===== bench/bmx_byte_move_props.sv
// Port-level assertions for the byte move sequencer
`timescale 1ns/1ps
module bmx_byte_move_props (
    input wire logic             clock,
    input wire logic             rst,
    input wire logic             opValid,
    input wire bmx_pkg::bmx_op_s opIn,
    input wire logic             issueReady,
    input wire logic             memReq,
    input wire logic             memWrite,
    input wire logic [31:0]      memAddr,
    input wire logic             memAck,
    input wire logic [7:0]       memRdata,
    input wire logic [7:0]       condition_code_reg,
    input wire logic             done,
    input wire logic [3:0]       instLen
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic       take;
    logic [3:0] lenReg;
    logic [3:0] lenNext;
    assign take = opValid && issueReady;
    always_comb begin
        lenNext = lenReg;
        if (take) begin
            case (opIn.mode)
                bmx_pkg::LD_D16, bmx_pkg::ST_D16: lenNext = 4'h4;
                bmx_pkg::LD_ABS16, bmx_pkg::ST_ABS16: lenNext = 4'h4;
                bmx_pkg::LD_D24, bmx_pkg::ST_D24: lenNext = 4'h8;
                bmx_pkg::LD_ABS24, bmx_pkg::ST_ABS24: lenNext = 4'h6;
                default: lenNext = 4'h2;
            endcase
        end
    end
    always_ff @(posedge clock) begin
        if (rst) lenReg <= 4'h0;
        else lenReg <= lenNext;
    end
    sequence s_load_ack;
        memReq && memAck && !memWrite;
    endsequence
    sequence s_flags_set;
        ##2 done && condition_code_reg[3] == $past(memRdata[7], 2) && condition_code_reg[2] == ($past(memRdata, 2) == 8'h00);
    endsequence
    a_load_flags: assert property (s_load_ack |-> s_flags_set)
        else $error("load flags wrong");
    a_ovf_clear: assert property (done |-> !condition_code_reg[1])
        else $error("overflow flag not cleared");
    a_carry_mask: assert property (!$past(rst) |-> $stable({condition_code_reg[7:6], condition_code_reg[0]}))
        else $error("carry or mask bits changed");
    a_done_pulse: assert property (done |-> issueReady ##1 !done)
        else $error("done not a single pulse");
    a_wait_hold: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
        else $error("access dropped during wait");
    a_postinc_access: assert property (take && opIn.mode == bmx_pkg::LD_POSTINC |-> ##4 memReq)
        else $error("postinc access late");
    a_d16_access: assert property (take && opIn.mode == bmx_pkg::LD_D16 |-> ##4 memReq && !memWrite)
        else $error("d16 load access late");
    a_d24_access: assert property (take && opIn.mode == bmx_pkg::LD_D24 |-> ##8 memReq && !memWrite)
        else $error("d24 load access late");
    a_st16_access: assert property (take && opIn.mode == bmx_pkg::ST_D16 |-> ##4 memReq && memWrite)
        else $error("d16 store access late");
    a_len_report: assert property (done |-> instLen == lenReg)
        else $error("instruction length wrong");
    a_imm_states: assert property (take && opIn.mode == bmx_pkg::MV_IMM |-> ##2 done)
        else $error("immediate move timing wrong");
endmodule
bind bmx_byte_move bmx_byte_move_props u_props (.clock(clock), .rst(rst), .opValid(opValid),
    .opIn(opIn), .issueReady(issueReady), .memReq(memReq), .memWrite(memWrite),
    .memAddr(memAddr), .memAck(memAck), .memRdata(memRdata), .condition_code_reg(condition_code_reg), .done(done),
    .instLen(instLen));

// ===== bench/tb.sv
// Self-checking bench for the byte move sequencer
`timescale 1ns/1ps
module tb;
    logic               clock = 1'b0;
    logic               rst = 1'b1;
    logic               opValid = 1'b0;
    bmx_pkg::bmx_op_s   opIn = '0;
    logic               memAck = 1'b0;
    logic [7:0]         memRdata = 8'h00;
    logic [2:0]         viewSel = 3'h0;
    bmx_pkg::bmx_view_e viewKind = bmx_pkg::VIEW_LOW_WORD;
    logic               issueReady, memReq, memWrite, done;
    logic [31:0]        memAddr;
    logic [7:0]         memWdata, condition_code_reg, ccrM;
    logic [3:0]         instLen;
    logic [15:0]        viewData;
    logic [31:0]        rs = 32'h00017DFD;
    logic [31:0]        regM [8];
    int                 miscompares = 0;
    int                 comparisons = 0;
    int                 cycles = 0;
    bmx_byte_move uut (.clock(clock), .rst(rst), .opValid(opValid), .opIn(opIn),
        .issueReady(issueReady), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
        .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata), .condition_code_reg(condition_code_reg), .done(done),
        .instLen(instLen), .viewSel(viewSel), .viewKind(viewKind), .viewData(viewData));

    always #2.5 clock = ~clock;

    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    task automatic check(string w, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Leaves opValid high with a junk op: must stay refused while busy
    task automatic run_op(bmx_pkg::bmx_mode_e m, logic [3:0] d, logic [3:0] s,
                          logic [2:0] a, logic [23:0] opd, int w);
        logic [31:0] ea;
        logic [7:0]  b;
        logic        st;
        logic        mem;
        int          n;
        int          cnt;
        int          len;
        st = (m >= bmx_pkg::ST_IND);
        mem = (m > bmx_pkg::MV_REG);
        ea = regM[a];
        n = 6;
        len = 2;
        case (m)
            bmx_pkg::MV_IMM, bmx_pkg::MV_REG: n = 2;
            bmx_pkg::LD_IND, bmx_pkg::ST_IND: n = 4;
            bmx_pkg::LD_ABS8, bmx_pkg::ST_ABS8: begin
                n = 4;
                ea = {bmx_pkg::ABS8_PAGE, opd[7:0]};
            end
            bmx_pkg::LD_D16, bmx_pkg::ST_D16: begin
                len = 4;
                ea = regM[a] + {{16{opd[15]}}, opd[15:0]};
            end
            bmx_pkg::LD_D24, bmx_pkg::ST_D24: begin
                n = 10;
                len = 8;
                ea = regM[a] + {{8{opd[23]}}, opd};
            end
            bmx_pkg::LD_ABS16, bmx_pkg::ST_ABS16: begin
                len = 4;
                ea = {{16{opd[15]}}, opd[15:0]};
            end
            bmx_pkg::LD_ABS24, bmx_pkg::ST_ABS24: begin
                n = 8;
                len = 6;
                ea = {8'h00, opd};
            end
            bmx_pkg::ST_PREDEC: ea = regM[a] - 32'h0000_0001;
            default: ;
        endcase
        b = (m == bmx_pkg::MV_IMM) ? opd[7:0] : (st || m == bmx_pkg::MV_REG) ?
            (s[3] ? regM[s[2:0]][7:0] : regM[s[2:0]][15:8]) : 8'(rnd());
        // Wait states only stretch ops that reach memory
        if (mem) n += w;
        // Always let one edge pass so opValid is never driven twice in a step
        do @(negedge clock); while (issueReady !== 1'b1);
        opIn = '{m, d, s, a, opd};
        opValid = 1'b1;
        cnt = 0;
        while (cnt < 40) begin
            @(negedge clock);
            cnt++;
            memAck = 1'b0;
            memRdata = 8'(rnd());
            // Drop the request before the done edge, where it would be taken
            if (done === 1'b1) begin
                opValid = 1'b0;
                break;
            end
            opIn = '{bmx_pkg::MV_IMM, 4'h8, 4'h0, 3'h0, 24'h00005A};
            if (memReq === 1'b1 && w > 0) w--;
            else if (memReq === 1'b1) begin
                memAck = 1'b1;
                memRdata = b;
                check("memAddr", ea, memAddr);
                check("memWrite", st, memWrite);
                if (st) check("memWdata", b, memWdata);
            end
        end
        if (m == bmx_pkg::LD_POSTINC) regM[a] += 1;
        if (m == bmx_pkg::ST_PREDEC) regM[a] -= 1;
        if (!st && d[3]) regM[d[2:0]][7:0] = b;
        if (!st && !d[3]) regM[d[2:0]][15:8] = b;
        ccrM = {ccrM[7:4], b[7], b == 8'h00, 1'b0, ccrM[0]};
        check("states", n, cnt);
        check("ccr", ccrM, condition_code_reg);
        check("instLen", len, instLen);
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            complete_run();
        end
    end

    initial begin
        bmx_pkg::bmx_mode_e m;
        logic [15:0]        e;
        for (int i = 0; i < 8; i++) regM[i] = 32'h0;
        ccrM = 8'h80;
        repeat (10) @(negedge clock);
        check("ccrReset", 8'h80, condition_code_reg);
        check("readyReset", 1'b0, issueReady);
        rst = 1'b0;
        $display("test reset done");
        run_op(bmx_pkg::MV_IMM, 4'h7, 4'h0, 3'h0, 24'h0000FF, 0);
        run_op(bmx_pkg::MV_IMM, 4'hF, 4'h0, 3'h0, 24'h0000FF, 0);
        run_op(bmx_pkg::MV_IMM, 4'h1, 4'h0, 3'h0, 24'h000000, 0);
        run_op(bmx_pkg::LD_POSTINC, 4'h9, 4'h0, 3'h7, 24'h000000, 1);
        run_op(bmx_pkg::ST_D16, 4'h0, 4'hF, 3'h7, 24'h00FFFF, 0);
        $display("test directed done");
        for (int i = 0; i < 64; i++) begin
            m = bmx_pkg::bmx_mode_e'(4'(rnd()));
            run_op(m, 4'(rnd()), 4'(rnd()), 3'(rnd()), 24'(rnd()), rnd() % 3);
        end
        $display("test random done");
        for (int r = 0; r < 32; r++) begin
            viewSel = r[4:2];
            viewKind = bmx_pkg::bmx_view_e'(r[1:0]);
            @(negedge clock);
            @(negedge clock);
            e = (r[1:0] == 2'h0) ? regM[r[4:2]][15:0] : (r[1:0] == 2'h1) ?
                regM[r[4:2]][31:16] : (r[1:0] == 2'h2) ? {8'h00, regM[r[4:2]][15:8]} :
                {8'h00, regM[r[4:2]][7:0]};
            check("viewData", e, viewData);
        end
        $display("test views done");
        complete_run();
    end
endmodule
